// ### logic/cctm_threshold_match.sv
// Purpose: debounced cc threshold match and change status, ahb-lite registers
// Assumes: comparator outputs are asynchronous levels, one per threshold per pin
// Notes:   zero wait state slave; irq high while an unmasked status bit is set
//
// Behaviour
// - each pin has eight thresholds, each owning one bit of match, change, enable and clear masks.
// - threshold 7 only reports the vendor high-voltage advertisement.
// - in sink role the source current level is decoded from the match bits.
// - source role cable detection uses thresholds 0, 1 and 3 for default, mid and high.
// - source role sink detection uses threshold 5 for default and mid and 6 for high.
// - sink role source detection uses thresholds 0, 2 and 4 for default, mid and high.
// - source role with only a powered cable reads an all-zero match vector.
// - source role with a sink attached matches only the cable threshold of the level.
// - source role open line matches cable and sink thresholds, vendor mode only threshold 7.
// - sink role matches 0, then 0 and 2, then 0, 2 and 4, plus 7 for a vendor source.
// - a powered cable without a sink shows no match and no change bit.
// - with thresholds 3 and 6 enabled a high sink sets only bit 3 after the debounce time.
// - with mask 0x15 a high source sets match and change bits 0, 2 and 4.
// - first debounce of both pins raises match valid, later changes raise the pin event, and irq when that pin's mask bit is set.
`timescale 1ns/10ps
module cctm_threshold_match (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic [31:0]                hrdata,
    output logic                       hresp,
    input  wire cctm_pkg::cctm_cmp_type cmp_in,
    output logic                       irq,
    output logic                       match_valid_event,
    output logic                       pin1_change_event,
    output logic                       pin2_change_event
);
    localparam int NP = cctm_pkg::NUM_PIN;
    localparam int NT = cctm_pkg::NUM_THR;

    // =========================================================
    // state
    cctm_pkg::cctm_cmp_type          sync1_ff, sync2_ff;
    logic [3:0]                      ctrl_ff, nxt_ctrl;
    logic [cctm_pkg::DEB_W-1:0]      deb_ff, nxt_deb;
    logic [NP-1:0][NT-1:0]           cc_match_enable_mask_ff, nxt_men;
    logic [NP-1:0][NT-1:0]           cc_debounce_clear_mask_ff, nxt_dbc;
    logic [NP-1:0][NT-1:0]           cc_match_vector_ff, nxt_match;
    logic [NP-1:0][NT-1:0]           cc_change_status_vector_ff, nxt_chg;
    logic [NP-1:0][NT-1:0]           prev_ff, nxt_prev;
    logic [NP-1:0][cctm_pkg::DEB_W-1:0] cnt_ff, nxt_cnt;
    logic [NP-1:0]                   done_ff, nxt_done;
    logic [NP-1:0]                   pin_evt;
    logic [NP-1:0][NT-1:0]           chg_clr;
    cctm_pkg::cctm_attach_type [NP-1:0] att_ff, nxt_att;
    logic [2:0]                      int_sts_ff, nxt_int_sts;
    logic [2:0]                      int_mask_ff, nxt_int_mask;
    logic                            valid_seen_ff, nxt_valid_seen;
    logic                            wr_ff, nxt_wr;
    logic [cctm_pkg::ADDR_W-1:0]     waddr_ff, nxt_waddr;
    logic [31:0]                     hrdata_ff, nxt_hrdata;
    logic                            irq_ff, nxt_irq;
    logic                            valid_evt_ff, nxt_valid_evt;
    logic [NP-1:0]                   pin_evt_ff;
    logic                            deb_en, role_sink;
    logic [1:0]                      adv;

    assign deb_en    = ctrl_ff[cctm_pkg::CTRL_DEB_EN_BIT];
    assign role_sink = ctrl_ff[cctm_pkg::CTRL_ROLE_BIT];
    assign adv       = ctrl_ff[cctm_pkg::CTRL_ADV_LSB +: 2];

    // =========================================================
    // comparator synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= cmp_in;
            sync2_ff <= sync1_ff;
        end
    end

    // =========================================================
    // per-pin debounce, match and change status
    for (genvar p = 0; p < NP; p++) begin : g_pin
        logic [NT-1:0] sample;
        logic [NT-1:0] cab_m, snk_m, snk_lvl;
        logic          load;

        always_comb begin
            sample       = sync2_ff.pin[p] & cc_match_enable_mask_ff[p];
            load         = 1'b0;
            nxt_prev[p]  = sample;
            nxt_cnt[p]   = cnt_ff[p];
            nxt_done[p]  = done_ff[p];
            nxt_match[p] = cc_match_vector_ff[p];
            if (!deb_en) begin
                nxt_cnt[p]  = '0;
                nxt_done[p] = 1'b0;
            end else if (|((sample ^ prev_ff[p]) & cc_debounce_clear_mask_ff[p])) begin
                nxt_cnt[p] = '0;
            end else if (sample != cc_match_vector_ff[p] || !done_ff[p]) begin
                if (cnt_ff[p] >= deb_ff) begin
                    load         = 1'b1;
                    nxt_match[p] = sample;
                    nxt_cnt[p]   = '0;
                    nxt_done[p]  = 1'b1;
                end else begin
                    nxt_cnt[p] = cnt_ff[p] + 1'b1;
                end
            end else begin
                nxt_cnt[p] = '0;
            end
            pin_evt[p] = load & done_ff[p] & (sample != cc_match_vector_ff[p]);
            // set wins over a same-cycle software clear
            nxt_chg[p] = (cc_change_status_vector_ff[p] & ~chg_clr[p])
                       | (load ? (sample ^ cc_match_vector_ff[p]) : '0);
        end

        // attach decode of the debounced match vector
        always_comb begin
            case (adv)
                cctm_pkg::ADV_DEFAULT: begin
                    cab_m = cctm_pkg::SRC_CABLE_LEVEL_DEFAULT;
                    snk_m = cctm_pkg::SRC_SINK_LEVEL_DEFAULT;
                end
                cctm_pkg::ADV_MID: begin
                    cab_m = cctm_pkg::SRC_CABLE_LEVEL_MID;
                    snk_m = cctm_pkg::SRC_SINK_LEVEL_MID;
                end
                cctm_pkg::ADV_HIGH: begin
                    cab_m = cctm_pkg::SRC_CABLE_LEVEL_HIGH;
                    snk_m = cctm_pkg::SRC_SINK_LEVEL_HIGH;
                end
                default: begin
                    cab_m = '0;
                    snk_m = '0;
                end
            endcase
            snk_lvl = cc_match_vector_ff[p];
            if (!done_ff[p]) begin
                nxt_att[p] = cctm_pkg::ATT_NONE;
            end else if (role_sink) begin
                if (|(snk_lvl & cctm_pkg::VENDOR_LEVEL_MASK)) begin
                    nxt_att[p] = cctm_pkg::ATT_SRC_VEND;
                end else if (|(snk_lvl & cctm_pkg::SNK_SOURCE_LEVEL_HIGH)) begin
                    nxt_att[p] = cctm_pkg::ATT_SRC_HIGH;
                end else if (|(snk_lvl & cctm_pkg::SNK_SOURCE_LEVEL_MID)) begin
                    nxt_att[p] = cctm_pkg::ATT_SRC_MID;
                end else if (|(snk_lvl & cctm_pkg::SNK_SOURCE_LEVEL_DEFAULT)) begin
                    nxt_att[p] = cctm_pkg::ATT_SRC_DEF;
                end else begin
                    nxt_att[p] = cctm_pkg::ATT_NONE;
                end
            end else if (adv == cctm_pkg::ADV_VENDOR) begin
                nxt_att[p] = (snk_lvl == cctm_pkg::VENDOR_LEVEL_MASK) ? cctm_pkg::ATT_OPEN
                                                                     : cctm_pkg::ATT_NONE;
            end else if (snk_lvl == '0) begin
                nxt_att[p] = cctm_pkg::ATT_CABLE;
            end else if (snk_lvl == (cab_m | snk_m)) begin
                nxt_att[p] = cctm_pkg::ATT_OPEN;
            end else if (snk_lvl == cab_m) begin
                nxt_att[p] = cctm_pkg::ATT_SINK;
            end else begin
                nxt_att[p] = cctm_pkg::ATT_NONE;
            end
        end

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                prev_ff[p]                    <= '0;
                cnt_ff[p]                     <= '0;
                done_ff[p]                    <= 1'b0;
                cc_match_vector_ff[p]         <= '0;
                cc_change_status_vector_ff[p] <= '0;
                att_ff[p]                     <= cctm_pkg::ATT_NONE;
                pin_evt_ff[p]                 <= 1'b0;
            end else begin
                prev_ff[p]                    <= nxt_prev[p];
                cnt_ff[p]                     <= nxt_cnt[p];
                done_ff[p]                    <= nxt_done[p];
                cc_match_vector_ff[p]         <= nxt_match[p];
                cc_change_status_vector_ff[p] <= nxt_chg[p];
                att_ff[p]                     <= nxt_att[p];
                pin_evt_ff[p]                 <= pin_evt[p];
            end
        end

        a_mask_blocks_set: assert property (@(posedge hclk) disable iff (!hresetn)
            ((cc_match_vector_ff[p] & ~$past(cc_match_vector_ff[p]) & ~$past(cc_match_enable_mask_ff[p]))
             == '0))
            else $error("match bit set for a disabled threshold");
        a_change_follows_match: assert property (@(posedge hclk) disable iff (!hresetn)
            (cc_match_vector_ff[p] != $past(cc_match_vector_ff[p])) |->
            ((cc_change_status_vector_ff[p] & (cc_match_vector_ff[p] ^ $past(cc_match_vector_ff[p])))
             == (cc_match_vector_ff[p] ^ $past(cc_match_vector_ff[p]))))
            else $error("change bit missing for a match change");
        a_change_stays_set: assert property (@(posedge hclk) disable iff (!hresetn)
            ((($past(cc_change_status_vector_ff[p]) & ~$past(chg_clr[p]))
              & ~cc_change_status_vector_ff[p]) == '0))
            else $error("change bit dropped without a clear");
        a_debounce_wait: assert property (@(posedge hclk) disable iff (!hresetn)
            (cc_match_vector_ff[p] != $past(cc_match_vector_ff[p])) |->
            ($past(cnt_ff[p]) >= $past(deb_ff)))
            else $error("match updated before the debounce time");
        a_sink_high_level: assert property (@(posedge hclk) disable iff (!hresetn)
            (done_ff[p] && role_sink && cc_match_vector_ff[p] == 8'h15) |=>
            (att_ff[p] == cctm_pkg::ATT_SRC_HIGH))
            else $error("high source not decoded in sink role");
        a_src_sink_seen: assert property (@(posedge hclk) disable iff (!hresetn)
            (done_ff[p] && !role_sink && adv == cctm_pkg::ADV_HIGH && cc_match_vector_ff[p] == 8'h08)
            ##1 (!role_sink && adv == cctm_pkg::ADV_HIGH) |-> (att_ff[p] == cctm_pkg::ATT_SINK))
            else $error("sink attach not decoded in source role");
        a_src_open_seen: assert property (@(posedge hclk) disable iff (!hresetn)
            (done_ff[p] && !role_sink && adv == cctm_pkg::ADV_MID && cc_match_vector_ff[p] == 8'h22)
            |=> (att_ff[p] == cctm_pkg::ATT_OPEN))
            else $error("open line not decoded in source role");
    end

    // =========================================================
    // match valid event at first debounce of both pins
    always_comb begin
        nxt_valid_seen = valid_seen_ff;
        nxt_valid_evt  = 1'b0;
        if (!deb_en) begin
            nxt_valid_seen = 1'b0;
        end else if (&done_ff && !valid_seen_ff) begin
            nxt_valid_seen = 1'b1;
            nxt_valid_evt  = 1'b1;
        end
    end

    // =========================================================
    // ahb-lite slave: write address captured, data applied next cycle
    always_comb begin
        logic                        take;
        logic [cctm_pkg::ADDR_W-1:0] a;
        logic                        wdp;
        take         = hsel & hready & htrans[1];
        a            = haddr[cctm_pkg::ADDR_W-1:0];
        wdp          = wr_ff;
        nxt_wr       = take & hwrite;
        nxt_waddr    = take ? a : waddr_ff;
        nxt_ctrl     = ctrl_ff;
        nxt_deb      = deb_ff;
        nxt_men      = cc_match_enable_mask_ff;
        nxt_dbc      = cc_debounce_clear_mask_ff;
        nxt_int_mask = int_mask_ff;
        chg_clr      = '0;
        nxt_int_sts  = int_sts_ff;
        if (wdp) begin
            case (waddr_ff)
                cctm_pkg::OFS_CTRL:     nxt_ctrl     = hwdata[3:0];
                cctm_pkg::OFS_DEB:      nxt_deb      = hwdata[cctm_pkg::DEB_W-1:0];
                cctm_pkg::OFS_MEN:      nxt_men[0]   = hwdata[7:0];
                cctm_pkg::OFS_MEN + cctm_pkg::PIN_STRIDE: nxt_men[1] = hwdata[7:0];
                cctm_pkg::OFS_DBC:      nxt_dbc[0]   = hwdata[7:0];
                cctm_pkg::OFS_DBC + cctm_pkg::PIN_STRIDE: nxt_dbc[1] = hwdata[7:0];
                cctm_pkg::OFS_CHG:      chg_clr[0]   = hwdata[7:0];
                cctm_pkg::OFS_CHG + cctm_pkg::PIN_STRIDE: chg_clr[1] = hwdata[7:0];
                cctm_pkg::OFS_INT_STS:  nxt_int_sts  = int_sts_ff & ~hwdata[2:0];
                cctm_pkg::OFS_INT_MASK: nxt_int_mask = hwdata[2:0];
                default: ;
            endcase
        end
        // hardware set wins over the write-one clear
        nxt_int_sts[cctm_pkg::INT_VALID_BIT] = nxt_int_sts[cctm_pkg::INT_VALID_BIT] | nxt_valid_evt;
        nxt_int_sts[cctm_pkg::INT_PIN1_BIT]  = nxt_int_sts[cctm_pkg::INT_PIN1_BIT] | pin_evt[0];
        nxt_int_sts[cctm_pkg::INT_PIN2_BIT]  = nxt_int_sts[cctm_pkg::INT_PIN2_BIT] | pin_evt[1];
        nxt_irq = |(int_sts_ff & int_mask_ff);
        nxt_hrdata = '0;
        if (take && !hwrite && haddr[31:cctm_pkg::ADDR_W] == '0) begin
            case (a)
                cctm_pkg::OFS_CTRL:     nxt_hrdata = {28'h0000000, ctrl_ff};
                cctm_pkg::OFS_DEB:      nxt_hrdata = {16'h0000, deb_ff};
                cctm_pkg::OFS_MEN:      nxt_hrdata = {24'h000000, cc_match_enable_mask_ff[0]};
                cctm_pkg::OFS_MEN + cctm_pkg::PIN_STRIDE:
                                        nxt_hrdata = {24'h000000, cc_match_enable_mask_ff[1]};
                cctm_pkg::OFS_DBC:      nxt_hrdata = {24'h000000, cc_debounce_clear_mask_ff[0]};
                cctm_pkg::OFS_DBC + cctm_pkg::PIN_STRIDE:
                                        nxt_hrdata = {24'h000000, cc_debounce_clear_mask_ff[1]};
                cctm_pkg::OFS_MATCH:    nxt_hrdata = {24'h000000, cc_match_vector_ff[0]};
                cctm_pkg::OFS_MATCH + cctm_pkg::PIN_STRIDE:
                                        nxt_hrdata = {24'h000000, cc_match_vector_ff[1]};
                cctm_pkg::OFS_CHG:      nxt_hrdata = {24'h000000, cc_change_status_vector_ff[0]};
                cctm_pkg::OFS_CHG + cctm_pkg::PIN_STRIDE:
                                        nxt_hrdata = {24'h000000, cc_change_status_vector_ff[1]};
                cctm_pkg::OFS_INT_STS:  nxt_hrdata = {29'h00000000, int_sts_ff};
                cctm_pkg::OFS_INT_MASK: nxt_hrdata = {29'h00000000, int_mask_ff};
                cctm_pkg::OFS_RAW:      nxt_hrdata = {16'h0000, sync2_ff.pin[1], sync2_ff.pin[0]};
                cctm_pkg::OFS_ATTACH:   nxt_hrdata = {25'h0000000, att_ff[1], 1'b0, att_ff[0]};
                default:                nxt_hrdata = '0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff                   <= cctm_pkg::CTRL_RESET;
            deb_ff                    <= cctm_pkg::DEB_RESET;
            cc_match_enable_mask_ff   <= '0;
            cc_debounce_clear_mask_ff <= '0;
            int_sts_ff                <= '0;
            int_mask_ff               <= '0;
            valid_seen_ff             <= 1'b0;
            valid_evt_ff              <= 1'b0;
            wr_ff                     <= 1'b0;
            waddr_ff                  <= '0;
            hrdata_ff                 <= '0;
            irq_ff                    <= 1'b0;
        end else begin
            ctrl_ff                   <= nxt_ctrl;
            deb_ff                    <= nxt_deb;
            cc_match_enable_mask_ff   <= nxt_men;
            cc_debounce_clear_mask_ff <= nxt_dbc;
            int_sts_ff                <= nxt_int_sts;
            int_mask_ff               <= nxt_int_mask;
            valid_seen_ff             <= nxt_valid_seen;
            valid_evt_ff              <= nxt_valid_evt;
            wr_ff                     <= nxt_wr;
            waddr_ff                  <= nxt_waddr;
            hrdata_ff                 <= nxt_hrdata;
            irq_ff                    <= nxt_irq;
        end
    end

    // zero wait states and always okay
    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign hrdata            = hrdata_ff;
    assign irq               = irq_ff;
    assign match_valid_event = valid_evt_ff;
    assign pin1_change_event = pin_evt_ff[0];
    assign pin2_change_event = pin_evt_ff[1];

    a_valid_once: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(&done_ff) && deb_en && $past(deb_en) |-> ##1 valid_evt_ff ##1 !valid_evt_ff)
        else $error("match valid event not a single pulse at first debounce");
    a_irq_tracks: assert property (@(posedge hclk) disable iff (!hresetn)
        (pin_evt[0] && int_mask_ff[cctm_pkg::INT_PIN1_BIT] && $stable(int_mask_ff)) |-> ##2 irq)
        else $error("pin change did not raise irq");
endmodule : cctm_threshold_match

// ### logic/cctm_pkg.sv
// Purpose: constants and types for the cc threshold match block
// Assumes: ahb-lite slave, 32-bit data, one word per register
// Notes:   thresholds and masks are bit positions in 8-bit vectors
package cctm_pkg;
    // =========================================================
    // sizes
    localparam int NUM_THR = 8;
    localparam int NUM_PIN = 2;
    localparam int ADDR_W  = 8;
    localparam int DEB_W   = 16;
    // =========================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_DEB      = 8'h04;
    localparam logic [7:0] OFS_MEN     = 8'h08;
    localparam logic [7:0] OFS_DBC     = 8'h10;
    localparam logic [7:0] OFS_MATCH   = 8'h18;
    localparam logic [7:0] OFS_CHG     = 8'h20;
    localparam logic [7:0] OFS_INT_STS  = 8'h28;
    localparam logic [7:0] OFS_INT_MASK = 8'h2c;
    localparam logic [7:0] OFS_RAW      = 8'h30;
    localparam logic [7:0] OFS_ATTACH   = 8'h34;
    localparam logic [7:0] PIN_STRIDE   = 8'h04;
    // =========================================================
    // field positions and reset values
    localparam int CTRL_DEB_EN_BIT = 0;
    localparam int CTRL_ROLE_BIT   = 1;
    localparam int CTRL_ADV_LSB    = 2;
    localparam int INT_VALID_BIT   = 0;
    localparam int INT_PIN1_BIT    = 1;
    localparam int INT_PIN2_BIT    = 2;
    localparam int ATT_PIN_SHIFT   = 4;
    localparam int RAW_PIN_SHIFT   = 8;
    localparam logic [3:0]       CTRL_RESET = 4'h0;
    localparam logic [DEB_W-1:0] DEB_RESET  = 16'h0100;
    // =========================================================
    // advertisement levels (ctrl adv field)
    localparam logic [1:0] ADV_DEFAULT = 2'h0;
    localparam logic [1:0] ADV_MID     = 2'h1;
    localparam logic [1:0] ADV_HIGH    = 2'h2;
    localparam logic [1:0] ADV_VENDOR  = 2'h3;
    // threshold masks per detection purpose
    localparam logic [7:0] SRC_CABLE_LEVEL_DEFAULT = 8'h01;
    localparam logic [7:0] SRC_CABLE_LEVEL_MID     = 8'h02;
    localparam logic [7:0] SRC_CABLE_LEVEL_HIGH    = 8'h08;
    localparam logic [7:0] SRC_SINK_LEVEL_DEFAULT  = 8'h20;
    localparam logic [7:0] SRC_SINK_LEVEL_MID      = 8'h20;
    localparam logic [7:0] SRC_SINK_LEVEL_HIGH     = 8'h40;
    localparam logic [7:0] SNK_SOURCE_LEVEL_DEFAULT = 8'h01;
    localparam logic [7:0] SNK_SOURCE_LEVEL_MID     = 8'h04;
    localparam logic [7:0] SNK_SOURCE_LEVEL_HIGH    = 8'h10;
    localparam logic [7:0] VENDOR_LEVEL_MASK        = 8'h80;
    // =========================================================
    // types
    typedef struct packed {
        logic [NUM_PIN-1:0][NUM_THR-1:0] pin;
    } cctm_cmp_type;

    typedef enum logic [2:0] {
        ATT_NONE     = 3'b000,
        ATT_CABLE    = 3'b001,
        ATT_SINK     = 3'b010,
        ATT_OPEN     = 3'b011,
        ATT_SRC_DEF  = 3'b100,
        ATT_SRC_MID  = 3'b101,
        ATT_SRC_HIGH = 3'b110,
        ATT_SRC_VEND = 3'b111
    } cctm_attach_type;
endpackage : cctm_pkg

// ### sim/cctm_cmp_model.sv
// Purpose: behavioural cc line comparators facing the threshold match block
// Assumes: line levels given in millivolts, nominal thresholds
// Notes:   a bit is high while its line stands above its threshold
`timescale 1ns/10ps
module cctm_cmp_model (
    input  int                     mv_cc1,
    input  int                     mv_cc2,
    output cctm_pkg::cctm_cmp_type cmp
);
    int thr_mv [8] = '{200, 400, 660, 800, 1230, 1600, 2600, 3000};
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            cmp.pin[0][i] = (mv_cc1 > thr_mv[i]);
            cmp.pin[1][i] = (mv_cc2 > thr_mv[i]);
        end
    end
endmodule : cctm_cmp_model

// ### sim/cctm_threshold_match_bench.sv
// Purpose: self-checking bench for the cc threshold match block
// Assumes: zero wait state slave, debounce count shortened to 4
// Notes:   expected match is the model level against thresholds, masked
`timescale 1ns/10ps
module cctm_threshold_match_bench;
    logic                   hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, hready, irq, valid_evt, pin1_evt, pin2_evt;
    logic [31:0]            haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]             htrans = 2'h0;
    logic [7:0]             m, ex, prev [2] = '{8'h00, 8'h00};
    logic [7:0]             sc_ctrl [6] = '{8'h05, 8'h09, 8'h0b, 8'h05, 8'h0b, 8'h0f};
    logic [7:0]             sc_mask [6] = '{8'h22, 8'h48, 8'h15, 8'h22, 8'h00, 8'h95};
    cctm_pkg::cctm_attach_type sc_att [6] = '{cctm_pkg::ATT_CABLE, cctm_pkg::ATT_SINK, cctm_pkg::ATT_SRC_HIGH,
                                             cctm_pkg::ATT_OPEN, cctm_pkg::ATT_NONE, cctm_pkg::ATT_SRC_VEND};
    int                     n_valid = 0, n_pin1 = 0, n_pin2 = 0;
    int                     sc_lo [6] = '{0, 850, 1300, 1700, 1300, 3100};
    int                     sc_span [6] = '{340, 1600, 740, 800, 700, 400};
    int                     v [2], mv1 = 0, mv2 = 0, fail_count = 0, n_checks = 0, seed = 32'ha0cb1cb9;
    cctm_pkg::cctm_cmp_type cmp;
    always #5 hclk = ~hclk;
    cctm_cmp_model PM (.mv_cc1(mv1), .mv_cc2(mv2), .cmp(cmp));
    cctm_threshold_match DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata),
        .hresp(), .cmp_in(cmp), .irq(irq), .match_valid_event(valid_evt), .pin1_change_event(pin1_evt),
        .pin2_change_event(pin2_evt));
    // event pulses last one cycle, so each is seen at exactly one falling edge
    always @(negedge hclk) begin
        if (valid_evt === 1'b1) n_valid++;
        if (pin1_evt === 1'b1) n_pin1++;
        if (pin2_evt === 1'b1) n_pin2++;
    end
    // ==========================================================
    // bus, compare and model
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hwrite <= w;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    function automatic logic [7:0] raw_of(input int mv);
        int t [8] = '{200, 400, 660, 800, 1230, 1600, 2600, 3000};
        raw_of = 8'h00;
        for (int i = 0; i < 8; i++) if (mv > t[i]) raw_of[i] = 1'b1;
    endfunction : raw_of
    // ==========================================================
    // scenarios
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, cctm_pkg::OFS_DEB, 32'h0);
        chk("debounce reset", 32'h0100, rd);
        $display("reset value test done");
        bus(1'b1, cctm_pkg::OFS_DEB, 32'h4);
        bus(1'b1, cctm_pkg::OFS_INT_MASK, 32'h7);
        for (int s = 0; s < 6; s++) begin
            m = sc_mask[s];
            bus(1'b1, cctm_pkg::OFS_CTRL, 32'h0);
            for (int p = 0; p < 2; p++) begin
                bus(1'b1, cctm_pkg::OFS_MEN + 8'(4 * p), {24'h0, m});
                bus(1'b1, cctm_pkg::OFS_DBC + 8'(4 * p), {24'h0, m});
                v[p] = sc_lo[s] + 1 + int'($unsigned($random(seed)) % sc_span[s]);
            end
            mv1 <= v[0];
            mv2 <= v[1];
            bus(1'b1, cctm_pkg::OFS_CTRL, {24'h0, sc_ctrl[s]});
            repeat (20) @(posedge hclk);
            for (int p = 0; p < 2; p++) begin
                ex = raw_of(v[p]) & m;
                bus(1'b0, cctm_pkg::OFS_MATCH + 8'(4 * p), 32'h0);
                chk("match", {24'h0, ex}, rd);
                bus(1'b0, cctm_pkg::OFS_CHG + 8'(4 * p), 32'h0);
                chk("change", {24'h0, prev[p] ^ ex}, rd);
                prev[p] = ex;
                bus(1'b1, cctm_pkg::OFS_CHG + 8'(4 * p), 32'hff);
            end
            bus(1'b0, cctm_pkg::OFS_ATTACH, 32'h0);
            chk("attach", 32'(17 * sc_att[s]), rd);
            chk("valid pulses", 32'(s + 1), n_valid);
            bus(1'b0, cctm_pkg::OFS_INT_STS, 32'h0);
            chk("match valid", 32'h1, {31'h0, rd[0]});
            chk("irq", 32'h1, {31'h0, irq});
            bus(1'b1, cctm_pkg::OFS_INT_STS, 32'h7);
            $display("scenario %0d done", s);
        end
        bus(1'b1, cctm_pkg::OFS_INT_MASK, 32'h3);
        mv2 <= 0;
        repeat (20) @(posedge hclk);
        bus(1'b0, cctm_pkg::OFS_INT_STS, 32'h0);
        chk("pin2 status", 32'h4, rd);
        chk("irq masked", 32'h0, {31'h0, irq});
        mv1 <= 0;
        repeat (20) @(posedge hclk);
        bus(1'b0, cctm_pkg::OFS_INT_STS, 32'h0);
        chk("pin1 status", 32'h6, rd);
        chk("irq pin1", 32'h1, {31'h0, irq});
        chk("pin1 pulses", 32'h1, n_pin1);
        chk("pin2 pulses", 32'h1, n_pin2);
        bus(1'b0, 8'h3c, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("later change done");
        conclude();
    end
    initial begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        conclude();
    end
endmodule : cctm_threshold_match_bench
